// *** rtl/panel_switch_ctrl.sv ***
// Touch panel switch matrix, bias and converter routing control
// Operation
// - Each panel terminal independently floating, biased or grounded from control register.
// - Terminal requested both biased and grounded is grounded only.
// - Touch detection and events keep working during standby.
// - Press event on detector falling edge, release on rising edge, when enabled and in interrupt mode.
// - Detectors sense both filtered X terminals and feed interrupt logic.
// - Mode 00 interrupt pull-up, 01 pressure active bias, 1X position active bias.
// - Pressure mode routes current monitor; other modes follow input select.
// - Mode and terminal settings live in control register at address 9.
// - Any one panel terminal selectable as converter input.
// - Powered and grounded assignments may be swapped freely.
// - Interrupt mode biases panel only through passive pull-up.
// - Converter multiplexer follows host converter input select field outside pressure mode.
`timescale 1ns/1ps
`default_nettype none

module panel_switch_ctrl (
	// Clock and reset
	input  wire logic        SYS_CLK_IN,
	input  wire logic        ARST_N_IN,
	// Register access from the serial control bus framing
	input  wire logic [3:0]  REG_ADDR_IN,
	input  wire logic        REG_WR_IN,
	input  wire logic        REG_RD_IN,
	input  wire logic [15:0] REG_WDATA_IN,
	output logic      [15:0] REG_RDATA_OUT,
	output logic             REG_RD_HIT_OUT,
	// Converter input select field and power state
	input  wire logic [2:0]  ADC_INPUT_SEL_IN,
	input  wire logic        STANDBY_IN,
	// Filtered Schmitt-trigger detector outputs on the X terminals
	input  wire logic        X_PLUS_DET_IN,
	input  wire logic        X_MINUS_DET_IN,
	// Edge enables from the shared interrupt controller
	input  wire logic        TOUCH_FALL_ENA_IN,
	input  wire logic        TOUCH_RISE_ENA_IN,
	// Switch matrix and bias controls
	output logic      [3:0]  TERM_POWER_EN_OUT,
	output logic      [3:0]  TERM_GROUND_EN_OUT,
	output logic             PULLUP_EN_OUT,
	output logic             BIAS_EN_OUT,
	output logic      [3:0]  ADC_MUX_SEL_OUT,
	// Touch events to the shared interrupt controller
	output logic             TOUCH_PRESS_OUT,
	output logic             TOUCH_RELEASE_OUT,
	output logic             TOUCH_LEVEL_OUT
);

	panel_touch_pkg::panel_ctrl_t ctrl_ff;
	panel_touch_pkg::panel_ctrl_t nxt_ctrl;
	logic [15:0]                  rdata_ff;
	logic [15:0]                  nxt_rdata;
	logic                         rd_hit_ff;
	logic                         nxt_rd_hit;
	logic [3:0]                   pow_ff;
	logic [3:0]                   nxt_pow;
	logic [3:0]                   gnd_ff;
	logic                         pullup_ff;
	logic                         nxt_pullup;
	logic                         bias_ff;
	logic                         nxt_bias;
	logic [3:0]                   mux_ff;
	logic [3:0]                   nxt_mux;
	logic                         press_ff;
	logic                         nxt_press;
	logic                         release_ff;
	logic                         nxt_release;
	logic                         touched_level;
	logic [0:0]                   touch_rise;
	logic [0:0]                   touch_fall;
	logic                         reg_sel;
	logic                         conflict;
	logic                         irq_mode;
	logic [15:0]                  readback;

	////////////////////////////////////////////////////////////////////////////////
	// Control register

	assign reg_sel = (REG_ADDR_IN == panel_touch_pkg::PANEL_CONTROL_ADDR);

	always_comb
	begin
		// A write and a read in one cycle return the old value
		nxt_ctrl = ctrl_ff;
		if (REG_WR_IN && reg_sel)
		begin
			nxt_ctrl.sw.pow = REG_WDATA_IN[panel_touch_pkg::POW_LSB +: 4];
			nxt_ctrl.sw.gnd = REG_WDATA_IN[panel_touch_pkg::GND_LSB +: 4];
			nxt_ctrl.mode = REG_WDATA_IN[panel_touch_pkg::MODE_LSB +: 2];
			nxt_ctrl.bias_ena = REG_WDATA_IN[panel_touch_pkg::BIAS_ENA_BIT];
		end
	end

	// Conflict shows the request as written, not the resolved switches
	assign conflict = |(ctrl_ff.sw.pow & ctrl_ff.sw.gnd);

	always_comb
	begin
		readback = 16'h0000;
		readback[panel_touch_pkg::POW_LSB +: 4] = ctrl_ff.sw.pow;
		readback[panel_touch_pkg::GND_LSB +: 4] = ctrl_ff.sw.gnd;
		readback[panel_touch_pkg::MODE_LSB +: 2] = ctrl_ff.mode;
		readback[panel_touch_pkg::BIAS_ENA_BIT] = ctrl_ff.bias_ena;
		// Live detector levels and conflict indication are read-only
		readback[panel_touch_pkg::DET_LSB] = X_PLUS_DET_IN;
		readback[panel_touch_pkg::DET_LSB + 1] = X_MINUS_DET_IN;
		readback[panel_touch_pkg::CONFLICT_BIT] = conflict;
	end

	always_comb
	begin
		// Read data holds until the next read, so the host may fetch it late
		nxt_rd_hit = REG_RD_IN && reg_sel;
		nxt_rdata = rdata_ff;
		if (REG_RD_IN && reg_sel)
		begin
			nxt_rdata = readback;
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			ctrl_ff.sw.pow <= panel_touch_pkg::PANEL_CONTROL_RESET[panel_touch_pkg::POW_LSB +: 4];
			ctrl_ff.sw.gnd <= panel_touch_pkg::PANEL_CONTROL_RESET[panel_touch_pkg::GND_LSB +: 4];
			ctrl_ff.mode <= panel_touch_pkg::PANEL_CONTROL_RESET[panel_touch_pkg::MODE_LSB +: 2];
			ctrl_ff.bias_ena <= panel_touch_pkg::PANEL_CONTROL_RESET[panel_touch_pkg::BIAS_ENA_BIT];
			rdata_ff <= 16'h0000;
			rd_hit_ff <= 1'b0;
		end
		else
		begin
			ctrl_ff <= nxt_ctrl;
			rdata_ff <= nxt_rdata;
			rd_hit_ff <= nxt_rd_hit;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Switch matrix, one switch pair per panel terminal

	// Each terminal resolves its own conflict, so one bad request never disturbs the rest
	for (genvar t = 0; t < panel_touch_pkg::NUM_TERMS; t++)
	begin : g_term
		logic term_pow_ff;
		logic nxt_term_pow;
		logic term_gnd_ff;
		logic nxt_term_gnd;

		always_comb
		begin
			// Ground always wins, so a terminal can never be shorted to the bias source
			nxt_term_gnd = ctrl_ff.sw.gnd[t];
			// Plates are treated alike, so powered and grounded roles may be swapped
			nxt_term_pow = ctrl_ff.sw.pow[t] && !ctrl_ff.sw.gnd[t];
		end

		// Reset opens both switches, leaving the terminal floating
		always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
		begin
			if (!ARST_N_IN)
			begin
				term_pow_ff <= 1'b0;
				term_gnd_ff <= 1'b0;
			end
			else
			begin
				term_pow_ff <= nxt_term_pow;
				term_gnd_ff <= nxt_term_gnd;
			end
		end

		assign nxt_pow[t] = nxt_term_pow;
		assign pow_ff[t] = term_pow_ff;
		assign gnd_ff[t] = term_gnd_ff;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bias source

	// Only interrupt mode may run the panel from the pull-up resistor
	assign irq_mode = (ctrl_ff.mode == panel_touch_pkg::MODE_INTERRUPT);

	always_comb
	begin
		// Interrupt mode feeds the powered terminals from the pull-up resistor only
		nxt_pullup = irq_mode && (|nxt_pow);
		// Standby drops the active bias but keeps the pull-up path for detection
		nxt_bias = !irq_mode && ctrl_ff.bias_ena && !STANDBY_IN;
	end

	always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			pullup_ff <= 1'b0;
			bias_ff <= 1'b0;
		end
		else
		begin
			pullup_ff <= nxt_pullup;
			bias_ff <= nxt_bias;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Converter input routing

	always_comb
	begin
		if (ctrl_ff.mode == panel_touch_pkg::MODE_PRESSURE)
		begin
			nxt_mux = panel_touch_pkg::MUX_CURRENT_MON;
		end
		else
		begin
			// Codes 0 to 3 pick one panel terminal, 4 to 7 the auxiliary inputs
			nxt_mux = {1'b0, ADC_INPUT_SEL_IN};
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			mux_ff <= 4'h0;
		end
		else
		begin
			mux_ff <= nxt_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Touch detection, independent of standby

	// Either X terminal dropping counts as touched
	assign touched_level = X_PLUS_DET_IN & X_MINUS_DET_IN;

	// Previous level starts high, matching an untouched panel after reset
	touch_edge_detect #(
		.CHANNELS (1)
	) u_edge (
		.clk_in    (SYS_CLK_IN),
		.arst_n_in (ARST_N_IN),
		.level_in  (touched_level),
		.rise_out  (touch_rise),
		.fall_out  (touch_fall)
	);

	always_comb
	begin
		// Only pulses leave; sticky status flags live in the shared interrupt controller
		// Measurement modes toggle the plates, so edges count only in interrupt mode
		nxt_press = touch_fall[0] && TOUCH_FALL_ENA_IN && irq_mode;
		nxt_release = touch_rise[0] && TOUCH_RISE_ENA_IN && irq_mode;
	end

	always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			press_ff <= 1'b0;
			release_ff <= 1'b0;
		end
		else
		begin
			press_ff <= nxt_press;
			release_ff <= nxt_release;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign REG_RDATA_OUT = rdata_ff;
	assign REG_RD_HIT_OUT = rd_hit_ff;
	assign TERM_POWER_EN_OUT = pow_ff;
	assign TERM_GROUND_EN_OUT = gnd_ff;
	assign PULLUP_EN_OUT = pullup_ff;
	assign BIAS_EN_OUT = bias_ff;
	assign ADC_MUX_SEL_OUT = mux_ff;
	assign TOUCH_PRESS_OUT = press_ff;
	assign TOUCH_RELEASE_OUT = release_ff;
	// Level is combinational so firmware can poll a touch without delay
	assign TOUCH_LEVEL_OUT = touched_level;

endmodule : panel_switch_ctrl

`default_nettype wire

// *** rtl/panel_touch_pkg.sv ***
// Shared constants and types for the resistive touch panel switch control
`default_nettype none

package panel_touch_pkg;

	// Panel terminal indices: x plus, x minus, y plus, y minus
	localparam int NUM_TERMS = 4;
	localparam int TERM_X_PLUS = 0;
	localparam int TERM_X_MINUS = 1;
	localparam int TERM_Y_PLUS = 2;
	localparam int TERM_Y_MINUS = 3;

	// Serial control bus register map
	localparam logic [3:0] PANEL_CONTROL_ADDR = 4'h9;

	// Field layout of panel_control
	localparam int POW_LSB = 0;
	localparam int GND_LSB = 4;
	localparam int MODE_LSB = 8;
	localparam int BIAS_ENA_BIT = 11;
	localparam int DET_LSB = 12;
	localparam int CONFLICT_BIT = 14;
	localparam logic [15:0] PANEL_CONTROL_RESET = 16'h0000;

	// Panel mode field encoding
	localparam logic [1:0] MODE_INTERRUPT = 2'h0;
	localparam logic [1:0] MODE_PRESSURE = 2'h1;

	// Converter multiplexer codes
	localparam logic [3:0] MUX_CURRENT_MON = 4'h8;

	typedef struct packed {
		logic [NUM_TERMS-1:0] pow;
		logic [NUM_TERMS-1:0] gnd;
	} switch_req_t;

	typedef struct packed {
		logic        bias_ena;
		logic [1:0]  mode;
		switch_req_t sw;
	} panel_ctrl_t;

endpackage : panel_touch_pkg

`default_nettype wire

// *** rtl/touch_edge_detect.sv ***
// Edge detector for filtered touch detector levels
`timescale 1ns/1ps
`default_nettype none

module touch_edge_detect #(
	parameter int CHANNELS = 1
) (
	// Clock and reset
	input  wire logic                clk_in,
	input  wire logic                arst_n_in,
	// Detector levels
	input  wire logic [CHANNELS-1:0] level_in,
	// One-cycle edge pulses
	output logic      [CHANNELS-1:0] rise_out,
	output logic      [CHANNELS-1:0] fall_out
);

	logic [CHANNELS-1:0] prev_ff;
	logic [CHANNELS-1:0] nxt_prev;
	logic [CHANNELS-1:0] rise_ff;
	logic [CHANNELS-1:0] nxt_rise;
	logic [CHANNELS-1:0] fall_ff;
	logic [CHANNELS-1:0] nxt_fall;

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		nxt_prev = level_in;
		nxt_rise = level_in & ~prev_ff;
		nxt_fall = ~level_in & prev_ff;
	end

	// Previous level resets high (untouched) so release of reset raises no event
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			prev_ff <= '1;
			rise_ff <= '0;
			fall_ff <= '0;
		end
		else
		begin
			prev_ff <= nxt_prev;
			rise_ff <= nxt_rise;
			fall_ff <= nxt_fall;
		end
	end

	assign rise_out = rise_ff;
	assign fall_out = fall_ff;

endmodule : touch_edge_detect

`default_nettype wire

// *** bench/panel_model.sv ***
// Behavioural four-wire panel feeding the filtered X detector levels
`timescale 1ns/1ps
`default_nettype none

module panel_model (
	// Switch matrix from the device
	input  wire logic [3:0] gnd_in,
	// Stylus contact from the bench
	input  wire logic       touch_in,
	// Filtered detector levels, high while untouched
	output logic            x_plus_det_out,
	output logic            x_minus_det_out
);
	// A press only pulls X low through a grounded Y plate
	always_comb x_plus_det_out = !(touch_in && (|gnd_in[3:2]));
	always_comb x_minus_det_out = x_plus_det_out;
endmodule : panel_model

`default_nettype wire

// *** bench/panel_switch_ctrl_chk.sv ***
// Port-level assertions for the panel switch control
`timescale 1ns/1ps
`default_nettype none

module panel_switch_ctrl_chk (
	input wire logic        SYS_CLK_IN,
	input wire logic        ARST_N_IN,
	input wire logic [3:0]  REG_ADDR_IN,
	input wire logic        REG_WR_IN,
	input wire logic        REG_RD_IN,
	input wire logic [15:0] REG_WDATA_IN,
	input wire logic [15:0] REG_RDATA_OUT,
	input wire logic        REG_RD_HIT_OUT,
	input wire logic [2:0]  ADC_INPUT_SEL_IN,
	input wire logic        STANDBY_IN,
	input wire logic        X_PLUS_DET_IN,
	input wire logic        X_MINUS_DET_IN,
	input wire logic        TOUCH_FALL_ENA_IN,
	input wire logic        TOUCH_RISE_ENA_IN,
	input wire logic [3:0]  TERM_POWER_EN_OUT,
	input wire logic [3:0]  TERM_GROUND_EN_OUT,
	input wire logic        PULLUP_EN_OUT,
	input wire logic        BIAS_EN_OUT,
	input wire logic [3:0]  ADC_MUX_SEL_OUT,
	input wire logic        TOUCH_PRESS_OUT,
	input wire logic        TOUCH_RELEASE_OUT,
	input wire logic        TOUCH_LEVEL_OUT
);
	logic [11:0] shadow_ff;
	logic [11:0] nxt_shadow;
	wire logic   wr9 = REG_WR_IN && (REG_ADDR_IN == panel_touch_pkg::PANEL_CONTROL_ADDR);
	wire logic   rd9 = REG_RD_IN && (REG_ADDR_IN == panel_touch_pkg::PANEL_CONTROL_ADDR);
	wire logic   det = X_PLUS_DET_IN && X_MINUS_DET_IN;
	wire logic [1:0] sh_mode = shadow_ff[9:8];
	wire logic [3:0] sh_pow = shadow_ff[3:0] & ~shadow_ff[7:4];

	// Shadow of the writable control bits; bit 10 never sticks
	always_comb nxt_shadow = wr9 ? (REG_WDATA_IN[11:0] & 12'hBFF) : shadow_ff;
	always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			shadow_ff <= 12'h000;
		end
		else
		begin
			shadow_ff <= nxt_shadow;
		end
	end

	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!ARST_N_IN);

	a_gnd_follow: assert property (TERM_GROUND_EN_OUT == $past(shadow_ff[7:4]))
		else $error("ground switches differ from request");
	a_pow_masked: assert property (
		TERM_POWER_EN_OUT == $past(sh_pow))
		else $error("power switches differ from request");
	a_no_short: assert property ((TERM_POWER_EN_OUT & TERM_GROUND_EN_OUT) == 4'h0)
		else $error("terminal both powered and grounded");
	a_pullup_mode: assert property (
		PULLUP_EN_OUT == ($past(sh_mode) == panel_touch_pkg::MODE_INTERRUPT
			&& $past(sh_pow) != 4'h0))
		else $error("pull-up state wrong");
	a_bias_mode: assert property (
		BIAS_EN_OUT == ($past(sh_mode) != 2'h0 && $past(shadow_ff[11])
			&& !$past(STANDBY_IN)))
		else $error("active bias state wrong");
	a_mux_route: assert property (
		ADC_MUX_SEL_OUT == (($past(sh_mode) == panel_touch_pkg::MODE_PRESSURE)
			? panel_touch_pkg::MUX_CURRENT_MON : {1'b0, $past(ADC_INPUT_SEL_IN)}))
		else $error("converter routing wrong");
	a_read_hit: assert property (REG_RD_HIT_OUT == $past(rd9))
		else $error("read hit pulse wrong");
	a_read_data: assert property (rd9 |=> REG_RDATA_OUT[11:0] == $past(shadow_ff))
		else $error("read data wrong");
	a_press_edge: assert property (
		TOUCH_PRESS_OUT == ($past(det, 3) && !$past(det, 2) && $past(TOUCH_FALL_ENA_IN)
			&& $past(sh_mode) == 2'h0))
		else $error("press event wrong");
	a_release_edge: assert property (
		TOUCH_RELEASE_OUT == (!$past(det, 3) && $past(det, 2) && $past(TOUCH_RISE_ENA_IN)
			&& $past(sh_mode) == 2'h0))
		else $error("release event wrong");
	a_level_and: assert property (TOUCH_LEVEL_OUT == det)
		else $error("touch level wrong");
endmodule : panel_switch_ctrl_chk

bind panel_switch_ctrl panel_switch_ctrl_chk chk (.*);

`default_nettype wire

// *** bench/panel_switch_ctrl_bench.sv ***
// Self-checking bench for the panel switch control
`timescale 1ns/1ps
`default_nettype none

module panel_switch_ctrl_bench;
	logic clk, rst_n, wr, rd, stby, fena, rena, touch, hit, press, rel, lvl, pu, bias, xp, xm;
	logic [3:0]  addr, pow, gnd, mux;
	logic [15:0] wdata, rdata, sh, rnd;
	logic [2:0]  sel;
	logic [15:0] exp_q[$];
	int compares, n_mismatch, n_press, n_rel, i, k, seed;

	panel_switch_ctrl uut (.SYS_CLK_IN(clk), .ARST_N_IN(rst_n), .REG_ADDR_IN(addr),
		.REG_WR_IN(wr), .REG_RD_IN(rd), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
		.REG_RD_HIT_OUT(hit), .ADC_INPUT_SEL_IN(sel), .STANDBY_IN(stby),
		.X_PLUS_DET_IN(xp), .X_MINUS_DET_IN(xm), .TOUCH_FALL_ENA_IN(fena),
		.TOUCH_RISE_ENA_IN(rena), .TERM_POWER_EN_OUT(pow), .TERM_GROUND_EN_OUT(gnd),
		.PULLUP_EN_OUT(pu), .BIAS_EN_OUT(bias), .ADC_MUX_SEL_OUT(mux),
		.TOUCH_PRESS_OUT(press), .TOUCH_RELEASE_OUT(rel), .TOUCH_LEVEL_OUT(lvl));
	panel_model far (.gnd_in(gnd), .touch_in(touch), .x_plus_det_out(xp), .x_minus_det_out(xm));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		compares++;
		if (seen !== want)
		begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : chk

	task automatic write(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wr <= 1'b1;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		if (a == panel_touch_pkg::PANEL_CONTROL_ADDR) sh = d & 16'h0BFF;
	endtask : write

	// Untouched panel: both detector bits read high
	task automatic read(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		if (a == panel_touch_pkg::PANEL_CONTROL_ADDR)
			exp_q.push_back({1'b0, |(sh[3:0] & sh[7:4]), 2'b11, sh[11:0]});
		@(posedge clk);
		rd <= 1'b0;
	endtask : read

	// Switch, bias and routing outputs against the last landed write
	task automatic outs;
		logic [3:0] p;
		logic       m0;
		p = sh[3:0] & ~sh[7:4];
		m0 = (sh[9:8] == panel_touch_pkg::MODE_INTERRUPT);
		chk({12'h000, pow}, {12'h000, p});
		chk({12'h000, gnd}, {12'h000, sh[7:4]});
		chk({14'h0000, pu, bias}, {14'h0000, m0 && |p, !m0 && sh[11] && !stby});
		chk({12'h000, mux}, (sh[9:8] == panel_touch_pkg::MODE_PRESSURE)
			? {12'h000, panel_touch_pkg::MUX_CURRENT_MON} : {13'h0000, sel});
	endtask : outs

	task automatic poke;
		touch <= 1'b1;
		repeat (10) @(posedge clk);
		touch <= 1'b0;
		repeat (10) @(posedge clk);
	endtask : poke

	task automatic results;
		$display("Comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	// Results are taken off the queue as the read strobe answers
	always @(posedge clk)
	begin
		if (hit === 1'b1 && exp_q.size() == 0) chk(16'h0001, 16'h0000);
		else if (hit === 1'b1) chk(rdata, exp_q.pop_front());
		if (press === 1'b1) n_press++;
		if (rel === 1'b1) n_rel++;
	end

	initial
	begin
		{rst_n, wr, rd, stby, fena, rena, touch, addr, wdata, sel, sh} = '0;
		seed = $urandom(20927);
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		read(4'h9);
		// Every mode code with random requests, conflicts included
		for (i = 0; i < 16; i++)
		begin
			rnd = 16'($urandom);
			rnd[9:8] = i[1:0];
			write(4'h9, rnd);
			sel <= 3'($urandom);
			read(4'h9);
			outs();
		end
		// Unmapped address must neither land nor answer
		write(4'hA, 16'hFFFF);
		read(4'hA);
		read(4'h9);
		outs();
		// Touch interrupt set-up: X powered, Y grounded, bias off
		write(4'h9, 16'h00C3);
		{stby, fena, rena} <= 3'b111;
		poke();
		outs();
		fena <= 1'b0;
		rena <= 1'b0;
		poke();
		// Pressure frame in standby, plate resistance both ways, then X position
		{fena, rena} <= 2'b11;
		write(4'h9, 16'h09C3);
		poke();
		outs();
		write(4'h9, 16'h0921);
		write(4'h9, 16'h0912);
		stby <= 1'b0;
		sel <= 3'h2;
		write(4'h9, 16'h0A21);
		read(4'h9);
		outs();
		for (k = 0; k < 20 && exp_q.size() != 0; k++) @(posedge clk);
		if (exp_q.size() != 0) n_mismatch++;
		chk(16'(n_press), 16'h0001);
		chk(16'(n_rel), 16'h0001);
		results();
	end
endmodule : panel_switch_ctrl_bench

`default_nettype wire
